//--- logic/agpfw_hub.sv
// agpfw_hub: hub end of the graphics port frame / fast write handshake.
// assumes the graphics end keeps its own block pacing; one clock domain.
// How it works
// - frame mode follows classic pci handshakes
// - frame and stop idle in pipe/sideband
// - fast write: hub drives frame out
// - initiator holds frame through the access
// - target latches cmd and address on frame
// - ready lines only pace data phases
// - irdy driven as initiator, sampled as target
// - once irdy asserted, no master waits inside a block
// - master pauses only at block boundaries
// - trdy sampled as initiator, driven as target
// - target readies per whole transfer or block
// - target waits only between blocks
// - no early trdy before first throttle
// - stop sampled as initiator, driven as target
`timescale 1ns/10ps
`default_nettype none
module agpfw_hub (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  agpfw_if.hub bus,
  input wire agpfw_pkg::agpfw_mode_t mode_i,
  input wire logic start_i,
  input wire logic [3:0] cmd_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0] len_i,
  input wire logic [31:0] wdata_i,
  input wire logic wdata_ok_i,
  input wire logic tgt_ready_i,
  input wire logic tgt_stop_i,
  output logic busy_o,
  output logic wdata_take_o,
  output logic done_o,
  output logic abort_o,
  output logic hit_o,
  output logic [3:0] hit_cmd_o,
  output logic [31:0] hit_addr_o,
  output logic [31:0] rx_data_o,
  output logic rx_valid_o
);
  typedef enum logic [2:0] {
    AGPFW_IDLE, AGPFW_ADDR, AGPFW_DATA, AGPFW_WAIT, AGPFW_TDATA
  } agpfw_hst_t;
  agpfw_hst_t st_q; // hub handshake state
  logic [7:0] left_q; // dwords still to send
  logic busy_q, take_q, done_q, abort_q, hit_q, rxv_q;
  logic [3:0] hcmd_q;
  logic [31:0] haddr_q, rxd_q;
  logic frame_q, frame_oe_q, irdy_q, irdy_oe_q; // initiator lines
  logic trdy_q, trdy_oe_q, stop_q, stop_oe_q; // target lines
  logic [31:0] ad_q;
  logic ad_oe_q;
  logic [3:0] cbe_q;
  logic cbe_oe_q;
  logic frame_mode, fw_mode, phase_done, blk_edge;
  // pipe/sideband keeps frame and stop idle
  assign frame_mode = (mode_i == agpfw_pkg::AGPFW_MODE_FRAME);
  assign fw_mode = (mode_i == agpfw_pkg::AGPFW_MODE_FASTWR);
  // a data phase completes when both ready lines are low
  assign phase_done = !bus.irdy_n && !bus.trdy_n;
  agpfw_blkcnt u_blk (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .clr_i(st_q == AGPFW_IDLE),
    .adv_i(st_q == AGPFW_DATA && phase_done),
    .idx_o(),
    .at_edge_o(blk_edge)
  );
  // main sequencer: initiator and target roles
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= AGPFW_IDLE;
      left_q <= 8'h00;
      frame_q <= 1'b1;
      irdy_q <= 1'b1;
      trdy_q <= 1'b1;
      stop_q <= 1'b1;
      frame_oe_q <= 1'b1;
      irdy_oe_q <= 1'b1;
      trdy_oe_q <= 1'b1;
      stop_oe_q <= 1'b1;
      ad_q <= agpfw_pkg::AD_RST;
      ad_oe_q <= 1'b1;
      cbe_q <= agpfw_pkg::CBE_RST;
      cbe_oe_q <= 1'b1;
      take_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      hit_q <= 1'b0;
      hcmd_q <= agpfw_pkg::CBE_RST;
      haddr_q <= agpfw_pkg::AD_RST;
      rxd_q <= agpfw_pkg::AD_RST;
      rxv_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      take_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      hit_q <= 1'b0;
      rxv_q <= 1'b0;
      unique case (st_q)
        AGPFW_IDLE: begin
          // release every line not owned in this role
          frame_oe_q <= 1'b1;
          irdy_oe_q <= 1'b1;
          trdy_oe_q <= 1'b1;
          stop_oe_q <= 1'b1;
          ad_oe_q <= 1'b1;
          cbe_oe_q <= 1'b1;
          busy_q <= 1'b0;
          if (start_i && (frame_mode || fw_mode) && len_i != 8'h00) begin
            // address phase as initiator, frame driven out
            frame_q <= 1'b0;
            frame_oe_q <= 1'b0;
            ad_q <= addr_i;
            ad_oe_q <= 1'b0;
            cbe_q <= cmd_i;
            cbe_oe_q <= 1'b0;
            irdy_q <= 1'b1;
            irdy_oe_q <= 1'b0;
            left_q <= len_i;
            busy_q <= 1'b1;
            st_q <= AGPFW_ADDR;
          end else if (frame_mode && !bus.frame_n) begin
            // target: capture command and address on first low frame
            hcmd_q <= bus.cbe_n;
            haddr_q <= bus.ad;
            hit_q <= 1'b1;
            trdy_q <= 1'b1;
            trdy_oe_q <= 1'b0;
            stop_q <= 1'b1;
            stop_oe_q <= 1'b0;
            busy_q <= 1'b1;
            st_q <= AGPFW_TDATA;
          end
        end
        AGPFW_ADDR, AGPFW_WAIT: begin
          // master asserts irdy only when all block data is at hand
          ad_q <= wdata_i;
          cbe_q <= 4'h0;
          if (wdata_ok_i) begin
            irdy_q <= 1'b0;
            take_q <= 1'b1;
            st_q <= AGPFW_DATA;
            // last phase: frame may only rise together with irdy low,
            // else the bus would look idle during a master pause
            if (left_q == 8'h01) begin
              frame_q <= 1'b1;
            end
          end else begin
            irdy_q <= 1'b1;
            st_q <= AGPFW_WAIT;
          end
        end
        AGPFW_DATA: begin
          if (!bus.stop_n) begin
            // target disconnect / retry / abort ends the access
            frame_q <= 1'b1;
            irdy_q <= 1'b1;
            abort_q <= 1'b1;
            st_q <= AGPFW_IDLE;
          end else if (phase_done) begin
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
              irdy_q <= 1'b1;
              frame_q <= 1'b1;
              done_q <= 1'b1;
              st_q <= AGPFW_IDLE;
            end else if (blk_edge && !wdata_ok_i) begin
              // only a block boundary may carry a master wait
              irdy_q <= 1'b1;
              st_q <= AGPFW_WAIT;
            end else begin
              // inside a block irdy stays low, no waits
              ad_q <= wdata_i;
              take_q <= 1'b1;
              if (left_q == 8'h02) begin
                frame_q <= 1'b1;
              end
            end
          end
        end
        AGPFW_TDATA: begin
          // target side: readiness and stop come from the user
          trdy_q <= !tgt_ready_i;
          stop_q <= !tgt_stop_i;
          if (!bus.irdy_n && !trdy_q) begin
            rxd_q <= bus.ad;
            rxv_q <= 1'b1;
          end
          if (bus.frame_n && (!trdy_q || !stop_q) && !bus.irdy_n) begin
            // last phase finished: turn lines back around
            trdy_q <= 1'b1;
            stop_q <= 1'b1;
            done_q <= 1'b1;
            st_q <= AGPFW_IDLE;
          end
        end
        default: begin
          st_q <= AGPFW_IDLE;
        end
      endcase
    end
  end
  assign bus.hub_frame_n = frame_q;
  assign bus.hub_frame_oe_n = frame_oe_q;
  assign bus.hub_irdy_n = irdy_q;
  assign bus.hub_irdy_oe_n = irdy_oe_q;
  assign bus.hub_trdy_n = trdy_q;
  assign bus.hub_trdy_oe_n = trdy_oe_q;
  assign bus.hub_stop_n = stop_q;
  assign bus.hub_stop_oe_n = stop_oe_q;
  assign bus.hub_ad = ad_q;
  assign bus.hub_ad_oe_n = ad_oe_q;
  assign bus.hub_cbe_n = cbe_q;
  assign bus.hub_cbe_oe_n = cbe_oe_q;
  assign busy_o = busy_q;
  assign wdata_take_o = take_q;
  assign done_o = done_q;
  assign abort_o = abort_q;
  assign hit_o = hit_q;
  assign hit_cmd_o = hcmd_q;
  assign hit_addr_o = haddr_q;
  assign rx_data_o = rxd_q;
  assign rx_valid_o = rxv_q;
endmodule : agpfw_hub
`default_nettype wire

//--- logic/agpfw_pkg.sv
// agpfw_pkg: shared constants and types for the graphics port handshake.
// assumes both ends run on one 40 MHz port clock.
package agpfw_pkg;
  // port operating modes
  typedef enum logic [1:0] {
    AGPFW_MODE_FRAME,
    AGPFW_MODE_FASTWR,
    AGPFW_MODE_PIPE,
    AGPFW_MODE_SBA
  } agpfw_mode_t;
  localparam int unsigned AD_W = 32; // address/data bus width
  localparam int unsigned CBE_W = 4; // command/byte-enable width
  localparam int unsigned BLOCK_BYTES = 32; // fast write block size
  localparam int unsigned BYTES_PER_PHASE = 4; // one dword per phase
  localparam int unsigned BLOCK_PHASES = BLOCK_BYTES / BYTES_PER_PHASE;
  localparam int unsigned LEN_W = 8; // transfer length in dwords
  localparam logic [2:0] BLOCK_LAST = 3'h7; // last phase index of a block
  localparam logic [AD_W-1:0] AD_RST = 32'h0000_0000; // reset of latches
  localparam logic [CBE_W-1:0] CBE_RST = 4'hf; // idle byte enables
endpackage : agpfw_pkg

//--- logic/agpfw_if.sv
// agpfw_if: the shared handshake wires between hub and graphics end.
// assumes a testbench resolves each line from the two output enables.
`timescale 1ns/10ps
`default_nettype none
interface agpfw_if (
  input wire logic core_clk_i
);
  // hub side drives, oe low means driving
  logic hub_frame_n, hub_frame_oe_n;
  logic hub_irdy_n, hub_irdy_oe_n;
  logic hub_trdy_n, hub_trdy_oe_n;
  logic hub_stop_n, hub_stop_oe_n;
  logic [31:0] hub_ad;
  logic hub_ad_oe_n;
  logic [3:0] hub_cbe_n;
  logic hub_cbe_oe_n;
  // graphics side drives
  logic gfx_frame_n, gfx_frame_oe_n;
  logic gfx_initiator_ready_n, gfx_irdy_oe_n;
  logic gfx_target_ready_n, gfx_trdy_oe_n;
  logic gfx_stop_n, gfx_stop_oe_n;
  logic [31:0] gfx_ad;
  logic gfx_ad_oe_n;
  logic [3:0] gfx_cmd_byte_en_n;
  logic gfx_cbe_oe_n;
  // resolved wire levels, computed by the testbench
  logic frame_n, irdy_n, trdy_n, stop_n;
  logic [31:0] ad;
  logic [3:0] cbe_n;
  modport hub (
    input core_clk_i, frame_n, irdy_n, trdy_n, stop_n, ad, cbe_n,
    output hub_frame_n, hub_frame_oe_n, hub_irdy_n, hub_irdy_oe_n,
    output hub_trdy_n, hub_trdy_oe_n, hub_stop_n, hub_stop_oe_n,
    output hub_ad, hub_ad_oe_n, hub_cbe_n, hub_cbe_oe_n
  );
  modport gfx (
    input core_clk_i, frame_n, irdy_n, trdy_n, stop_n, ad, cbe_n,
    output gfx_frame_n, gfx_frame_oe_n, gfx_initiator_ready_n,
    output gfx_irdy_oe_n, gfx_target_ready_n, gfx_trdy_oe_n,
    output gfx_stop_n, gfx_stop_oe_n, gfx_ad, gfx_ad_oe_n,
    output gfx_cmd_byte_en_n, gfx_cbe_oe_n
  );
endinterface : agpfw_if
`default_nettype wire

//--- logic/agpfw_blkcnt.sv
// agpfw_blkcnt: counts data phases inside a 32-byte block.
// assumes adv_i pulses once per completed dword phase.
`timescale 1ns/10ps
`default_nettype none
module agpfw_blkcnt (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic adv_i,
  output logic [2:0] idx_o,
  output logic at_edge_o
);
  logic [2:0] idx_q; // phase index in current block
  // wraps every eight dwords
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idx_q <= 3'h0;
    end else if (clr_i) begin
      idx_q <= 3'h0;
    end else if (adv_i) begin
      idx_q <= idx_q + 3'h1;
    end
  end
  assign idx_o = idx_q;
  // true on the last phase of a block
  assign at_edge_o = (idx_q == agpfw_pkg::BLOCK_LAST);
endmodule : agpfw_blkcnt
`default_nettype wire

//--- logic/agpfw_gfx.sv
// agpfw_gfx: graphics-controller end acting as fast write target.
// assumes the hub frames each write; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module agpfw_gfx (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  agpfw_if.gfx bus,
  input wire logic [7:0] len_i,
  input wire logic room_i,
  output logic [31:0] rx_data_o,
  output logic rx_valid_o,
  output logic active_o
);
  typedef enum logic [1:0] {AGPFW_G_IDLE, AGPFW_G_HOLD, AGPFW_G_RUN}
    agpfw_gst_t;
  agpfw_gst_t st_q; // target state
  logic trdy_q, trdy_oe_q; // target-ready line
  logic [31:0] rxd_q;
  logic rxv_q, act_q, blk_edge;
  logic beat;
  assign beat = (st_q == AGPFW_G_RUN) && !bus.irdy_n && !trdy_q;
  agpfw_blkcnt u_blk (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .clr_i(st_q == AGPFW_G_IDLE),
    .adv_i(beat),
    .idx_o(),
    .at_edge_o(blk_edge)
  );
  // trdy only when the whole transfer or next block fits
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= AGPFW_G_IDLE;
      trdy_q <= 1'b1;
      trdy_oe_q <= 1'b1;
      rxd_q <= agpfw_pkg::AD_RST;
      rxv_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      rxv_q <= beat;
      if (beat) begin
        rxd_q <= bus.ad;
      end
      unique case (st_q)
        AGPFW_G_IDLE: begin
          trdy_oe_q <= 1'b1;
          trdy_q <= 1'b1;
          act_q <= 1'b0;
          if (!bus.frame_n) begin
            trdy_oe_q <= 1'b0;
            act_q <= 1'b1;
            st_q <= AGPFW_G_HOLD;
          end
        end
        AGPFW_G_HOLD: begin
          // room_i covers min(len, one block); early trdy hangs
          if (room_i) begin
            trdy_q <= 1'b0;
            st_q <= AGPFW_G_RUN;
          end
        end
        AGPFW_G_RUN: begin
          if (beat && bus.frame_n) begin
            trdy_q <= 1'b1;
            st_q <= AGPFW_G_IDLE;
          end else if (beat && blk_edge &&
              len_i > 8'(agpfw_pkg::BLOCK_PHASES)) begin
            // waits only between blocks
            trdy_q <= 1'b1;
            st_q <= AGPFW_G_HOLD;
          end
        end
        default: begin
          st_q <= AGPFW_G_IDLE;
        end
      endcase
    end
  end
  assign bus.gfx_frame_n = 1'b1;
  assign bus.gfx_frame_oe_n = 1'b1;
  assign bus.gfx_initiator_ready_n = 1'b1;
  assign bus.gfx_irdy_oe_n = 1'b1;
  assign bus.gfx_target_ready_n = trdy_q;
  assign bus.gfx_trdy_oe_n = trdy_oe_q;
  assign bus.gfx_stop_n = 1'b1;
  assign bus.gfx_stop_oe_n = 1'b1;
  assign bus.gfx_ad = agpfw_pkg::AD_RST;
  assign bus.gfx_ad_oe_n = 1'b1;
  assign bus.gfx_cmd_byte_en_n = agpfw_pkg::CBE_RST;
  assign bus.gfx_cbe_oe_n = 1'b1;
  assign rx_data_o = rxd_q;
  assign rx_valid_o = rxv_q;
  assign active_o = act_q;
endmodule : agpfw_gfx
`default_nettype wire

//--- verif/agpfw_monitor.sv
// agpfw_monitor: handshake checks on the shared port wires.
// assumes resolved levels and enables come straight from agpfw_if.
`timescale 1ns/10ps
`default_nettype none
module agpfw_monitor (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic hub_frame_oe_n,
  input wire logic hub_trdy_oe_n,
  input wire logic hub_stop_oe_n,
  input wire logic gfx_frame_oe_n,
  input wire logic gfx_irdy_oe_n,
  input wire logic gfx_trdy_oe_n
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic beat; // completed data phase
  logic blk_end; // beat closing a 32-byte block
  logic [2:0] cnt_q; // beats inside current block
  assign beat = !irdy_n && !trdy_n;
  assign blk_end = beat && (cnt_q == agpfw_pkg::BLOCK_LAST);
  // block position; cleared on idle so each write starts aligned
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 3'h0;
    end else if (frame_n && irdy_n) begin
      cnt_q <= 3'h0;
    end else if (beat) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  AST_FRAME_HUB_ONLY: assert property (gfx_frame_oe_n)
    else $error("frame driven by graphics end");
  AST_IRDY_SAMPLED: assert property (gfx_irdy_oe_n)
    else $error("irdy driven by target end");
  AST_FRAME_RISE: assert property ($rose(frame_n) && stop_n |-> !irdy_n)
    else $error("frame ended without irdy");
  AST_IRDY_WAIT: assert property (!irdy_n && trdy_n && stop_n |=> !irdy_n)
    else $error("irdy withdrawn before data phase ended");
  AST_NO_MASTER_WAIT: assert property (
    beat && !frame_n && !blk_end |=> !irdy_n)
    else $error("master wait inside block");
  AST_TGT_NO_WAIT: assert property (
    beat && !frame_n && !blk_end |=> !trdy_n)
    else $error("target wait inside block");
  AST_EARLY_TRDY: assert property ($fell(frame_n) |-> trdy_n && irdy_n)
    else $error("ready asserted in address phase");
  AST_TRDY_SAMPLED: assert property (!hub_frame_oe_n |-> hub_trdy_oe_n)
    else $error("initiator drives trdy");
  AST_STOP_SAMPLED: assert property (!hub_frame_oe_n |-> hub_stop_oe_n)
    else $error("initiator drives stop");
  AST_TRDY_ONE_OWNER: assert property (!hub_trdy_oe_n |-> gfx_trdy_oe_n)
    else $error("two drivers on trdy");
  AST_TRDY_IN_XFER: assert property (!trdy_n |-> !frame_n || !irdy_n)
    else $error("trdy outside a transfer");
  // main scenarios: long burst, target pause, end of access
  cover property (blk_end && !frame_n);
  cover property (!frame_n && !irdy_n && trdy_n);
  cover property ($rose(frame_n));
  // master pause at a block edge while the hub owns frame
  cover property (!frame_n && irdy_n && !trdy_n && !hub_frame_oe_n);
endmodule : agpfw_monitor
`default_nettype wire

//--- verif/testbench.sv
// testbench: hub initiator writing into the graphics target end.
// assumes hub and gfx face each other through one agpfw_if.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam agpfw_pkg::agpfw_mode_t FW = agpfw_pkg::AGPFW_MODE_FASTWR;
  localparam agpfw_pkg::agpfw_mode_t FR = agpfw_pkg::AGPFW_MODE_FRAME;
  logic core_clk_i = 1'b0; // 40 MHz port clock
  logic nrst_i = 1'b1; // async reset, active low; falls at 1 ns
  logic wok = 1'b1; // hub write data source ready
  logic gact, abort_s, hit_s; // gfx activity, stray hub pulses
  logic stray = 1'b0; // abort or self-hit ever seen
  agpfw_pkg::agpfw_mode_t mode = FW;
  logic start = 1'b0; // request level
  logic room = 1'b1; // target buffer space
  logic [3:0] cmd = 4'h7;
  logic [7:0] len = 8'h01; // dwords, shared by both ends
  logic [31:0] addr = 32'h0;
  logic [31:0] wbase = 32'h0; // first dword of a write
  logic [31:0] exp_d = 32'h0; // next dword due at the target
  logic [31:0] ntake = 32'h0; // dwords taken by the hub
  logic [31:0] wdata, gdata;
  logic busy, take, done, gvalid;
  logic fr_q = 1'b1; // frame one edge ago
  logic fr_seen = 1'b0; // frame ever low
  int n_fail = 0;
  int num_checks = 0;
  int beats = 0;
  int cyc = 0;
  agpfw_if bi (.core_clk_i(core_clk_i));
  // open-drain style resolve: pulled high when nobody drives
  assign bi.frame_n = (bi.hub_frame_n | bi.hub_frame_oe_n) &
    (bi.gfx_frame_n | bi.gfx_frame_oe_n);
  assign bi.irdy_n = (bi.hub_irdy_n | bi.hub_irdy_oe_n) &
    (bi.gfx_initiator_ready_n | bi.gfx_irdy_oe_n);
  assign bi.trdy_n = (bi.hub_trdy_n | bi.hub_trdy_oe_n) &
    (bi.gfx_target_ready_n | bi.gfx_trdy_oe_n);
  assign bi.stop_n = (bi.hub_stop_n | bi.hub_stop_oe_n) &
    (bi.gfx_stop_n | bi.gfx_stop_oe_n);
  assign bi.ad = (bi.hub_ad | {32{bi.hub_ad_oe_n}}) &
    (bi.gfx_ad | {32{bi.gfx_ad_oe_n}});
  assign bi.cbe_n = (bi.hub_cbe_n | {4{bi.hub_cbe_oe_n}}) &
    (bi.gfx_cmd_byte_en_n | {4{bi.gfx_cbe_oe_n}});
  // next dword is ready while the take pulse of the last stands
  assign wdata = wbase + ntake + {31'h0, take};
  always #12.5 core_clk_i = ~core_clk_i;
  agpfw_hub agpfw_hub_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .bus(bi), .mode_i(mode), .start_i(start), .cmd_i(cmd),
    .addr_i(addr), .len_i(len), .wdata_i(wdata), .wdata_ok_i(wok),
    .tgt_ready_i(1'b0), .tgt_stop_i(1'b0), .busy_o(busy),
    .wdata_take_o(take), .done_o(done), .abort_o(abort_s), .hit_o(hit_s),
    .hit_cmd_o(), .hit_addr_o(), .rx_data_o(), .rx_valid_o());
  agpfw_gfx agpfw_gfx_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .bus(bi), .len_i(len), .room_i(room), .rx_data_o(gdata),
    .rx_valid_o(gvalid), .active_o(gact));
  agpfw_monitor agpfw_monitor_inst (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .frame_n(bi.frame_n), .irdy_n(bi.irdy_n),
    .trdy_n(bi.trdy_n), .stop_n(bi.stop_n),
    .hub_frame_oe_n(bi.hub_frame_oe_n), .hub_trdy_oe_n(bi.hub_trdy_oe_n),
    .hub_stop_oe_n(bi.hub_stop_oe_n), .gfx_frame_oe_n(bi.gfx_frame_oe_n),
    .gfx_irdy_oe_n(bi.gfx_irdy_oe_n), .gfx_trdy_oe_n(bi.gfx_trdy_oe_n));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // inputs set after tick move 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask : tick
  // bus watcher: address phase, data order, hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    fr_q <= bi.frame_n;
    if (take) ntake <= ntake + 1;
    if (abort_s || hit_s) stray <= 1'b1;
    if (!bi.frame_n) fr_seen <= 1'b1;
    if (fr_q && !bi.frame_n) begin
      check(bi.ad, addr);
      check({28'h0, bi.cbe_n}, {28'h0, cmd});
    end
    if (gvalid) begin
      check(gdata, exp_d);
      exp_d <= exp_d + 1;
      beats <= beats + 1;
    end
    if (cyc == 6000) begin
      n_fail++;
      final_report;
    end
  end
  // one write; stall holds room low at start and, when n is over 8, at the block edge
  task automatic write(input agpfw_pkg::agpfw_mode_t m,
    input logic [7:0] n, input logic [3:0] c, input int stall,
    input int mw);
    int i;
    mode = m;
    len = n;
    cmd = c;
    addr = {24'h400000, n};
    wbase = {8'h5a, 16'h0, n};
    exp_d = wbase;
    ntake = 32'h0;
    beats = 0;
    room = (stall == 0);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    if (mw > 0) begin
      // data source runs dry inside the first block: no wait until its end
      tick(1);
      wok = 1'b0;
      tick(12 + mw);
      check(beats, 8);
      wok = 1'b1;
    end
    if (stall > 0) begin
      tick(stall);
      check(beats, 0);
      check({31'h0, gact}, 32'h1);
      room = 1'b1;
    end
    if (n > 8 && stall > 0) begin
      for (i = 0; i < 300 && beats < 6; i++) tick(1);
      room = 1'b0;
      tick(stall + 2);
      check(beats, 8);
      room = 1'b1;
    end
    for (i = 0; i < 300 && !done; i++) tick(1);
    check({31'h0, done}, 32'h1);
    tick(2);
    check(beats, {24'h0, n});
    check({31'h0, busy}, 32'h0);
    check({31'h0, gact}, 32'h0);
    check({31'h0, stray}, 32'h0);
    $display("write test end mode=%0d len=%0d", m, n);
  endtask : write
  // start in a queued mode must leave frame untouched
  task automatic refused(input agpfw_pkg::agpfw_mode_t m);
    mode = m;
    len = 8'h04;
    fr_seen = 1'b0;
    start = 1'b1;
    tick(10);
    start = 1'b0;
    check({31'h0, fr_seen}, 32'h0);
    check({31'h0, busy}, 32'h0);
    $display("refusal test end mode=%0d", m);
  endtask : refused
  initial begin
    // a real falling edge, so the async reset branches do run
    #1 nrst_i = 1'b0;
    tick(8);
    nrst_i = 1'b1;
    tick(1);
    write(FW, 8'h04, 4'h7, 0, 0);
    write(FW, 8'h08, 4'h7, 3, 0);
    write(FW, 8'h14, 4'h7, 4, 0);
    write(FW, 8'h01, 4'h7, 0, 0);
    write(FR, 8'h02, 4'h6, 0, 0);
    refused(agpfw_pkg::AGPFW_MODE_PIPE);
    refused(agpfw_pkg::AGPFW_MODE_SBA);
    write(FW, 8'h09, 4'h7, 2, 0);
    write(FW, 8'h09, 4'h7, 0, 5);
    final_report;
  end
endmodule : testbench
`default_nettype wire
